// >>> core/ddhp_pkg.sv
// Purpose: shared constants and carrier types for the display driver host pad logic
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: pad straps are sampled levels, not software registers

package ddhp_pkg;

  // ----------------------------------------
  // interface mode straps
  // ----------------------------------------
  localparam logic [2:0] MODE_P8_6800 = 3'h0;
  localparam logic [2:0] MODE_P8_8080 = 3'h1;
  localparam logic [2:0] MODE_SPI4 = 3'h2;
  localparam logic [2:0] MODE_TWI_A = 3'h3;
  localparam logic [2:0] MODE_P4_6800 = 3'h4;
  localparam logic [2:0] MODE_P4_8080 = 3'h5;
  localparam logic [2:0] MODE_SPI3 = 3'h6;
  localparam logic [2:0] MODE_TWI_B = 3'h7;

  // ----------------------------------------
  // field positions and sizes
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDI = 1;
  localparam int SER_BITS = 8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] BITCNT_RST = 4'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int OSC_HZ = 1_000_000;
  localparam int OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
  localparam int ROW_CYC = 64;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic is_data;
    logic is_read;
    logic nibble_hi;
  } ddhp_xfer_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } ddhp_bus_t;

endpackage : ddhp_pkg

// >>> core/ddhp_sync.sv
// Purpose: two-flop synchroniser for pad inputs, one per bit
// Assumes: destination is the 50 MHz core clock
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module ddhp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ddhp_sync_st_t;

  ddhp_sync_st_t st_r;
  ddhp_sync_st_t st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule : ddhp_sync
`default_nettype wire

// >>> core/ddhp_top.sv
// Purpose: pad-level host front end of a display driver
// Assumes: host, data, clock and cascade input pads are asynchronous and are synchronised before use; straps are not
// Notes: strobes are edge-detected after sync, so host pulses must span 3+ clocks
`timescale 1ns/100ps
`default_nettype none

module ddhp_top #(
  parameter int OSC_HALF = ddhp_pkg::OSC_HALF_CYC,
  parameter int ROWS = 32,
  parameter int ROW_LEN = ddhp_pkg::ROW_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // host control pads
  input wire logic hw_init_n,
  input wire logic cs_n,
  input wire logic data_cmd_sel,
  input wire logic wr_dir,
  input wire logic rd_en,
  // data pads
  input wire logic [7:0] d_i,
  output logic [7:0] d_o,
  output logic [7:0] d_oe,
  // straps
  input wire logic [2:0] if_mode,
  input wire logic osc_enable_pad,
  input wire logic cascade_en,
  input wire logic cascade_master,
  // core side
  output ddhp_pkg::ddhp_xfer_t xfer,
  output logic xfer_vld,
  output logic slave_addr_lsb,
  output logic settings_init,
  input wire logic [7:0] rd_data,
  input wire logic display_on,
  input wire logic pattern_bit,
  // display clock pad
  input wire logic display_clk_pad_i,
  output logic display_clk_pad_o,
  output logic display_clk_pad_oe,
  output logic disp_clk_tick,
  // cascade pads
  input wire logic cascade_shift_clk_i,
  output logic cascade_shift_clk_o,
  output logic cascade_shift_clk_oe,
  input wire logic cascade_pattern_data_i,
  output logic cascade_pattern_data_o,
  output logic cascade_pattern_data_oe,
  input wire logic cascade_frame_sync_i,
  output logic cascade_frame_sync_o,
  output logic cascade_frame_sync_oe,
  output logic pattern_rx,
  output logic unused_latch_out,
  // indicators
  output logic frame_marker,
  output logic display_state
);

  // ----------------------------------------
  // synchronised pads
  // ----------------------------------------
  localparam int NS = 8 + 10;
  logic [NS-1:0] raw;
  logic [NS-1:0] syn;
  assign raw = {d_i, hw_init_n, cs_n, data_cmd_sel, wr_dir, rd_en, display_clk_pad_i,
                cascade_shift_clk_i, cascade_pattern_data_i, cascade_frame_sync_i,
                display_on};

  ddhp_sync #(.W(NS)) u_sync (
    .clock(clock),
    .rst(rst),
    .d(raw),
    .q(syn)
  );

  logic [7:0] s_d;
  logic s_init_n, s_cs_n, s_dc, s_wr, s_rd, s_eclk, s_sclk_c, s_pat, s_fs, s_don;
  assign {s_d, s_init_n, s_cs_n, s_dc, s_wr, s_rd, s_eclk, s_sclk_c, s_pat, s_fs,
          s_don} = syn;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic wr_q;
    logic rd_q;
    logic sclk_q;
    logic eclk_q;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic nib_hi;
    ddhp_pkg::ddhp_xfer_t xf;
    logic vld;
    logic [7:0] dout;
    logic [7:0] osc_cnt;
    logic osc;
    logic tick;
    logic [7:0] row_cnt;
    logic [5:0] row;
    logic fm;
    logic ds;
  } ddhp_st_t;

  ddhp_st_t st_r;
  ddhp_st_t st_nxt;

  logic is8080, is6800, is4bit, isser, isspi4, istwi, in_init;
  assign is8080 = (if_mode == ddhp_pkg::MODE_P8_8080) || (if_mode == ddhp_pkg::MODE_P4_8080);
  assign is6800 = (if_mode == ddhp_pkg::MODE_P8_6800) || (if_mode == ddhp_pkg::MODE_P4_6800);
  assign is4bit = if_mode[2] && !if_mode[1];
  assign istwi = (if_mode == ddhp_pkg::MODE_TWI_A) || (if_mode == ddhp_pkg::MODE_TWI_B);
  assign isspi4 = (if_mode == ddhp_pkg::MODE_SPI4);
  assign isser = !is8080 && !is6800;
  assign in_init = !s_init_n;

  logic sel;
  logic sclk_rise;
  logic clk_src;
  assign sel = !s_cs_n;
  assign sclk_rise = s_d[ddhp_pkg::PIN_SCLK] && !st_r.sclk_q;
  assign clk_src = osc_enable_pad ? st_r.osc : s_eclk;

  always_comb begin
    st_nxt = st_r;
    st_nxt.vld = 1'b0;
    st_nxt.tick = 1'b0;
    st_nxt.wr_q = s_wr;
    st_nxt.rd_q = s_rd;
    st_nxt.sclk_q = s_d[ddhp_pkg::PIN_SCLK];
    st_nxt.eclk_q = clk_src;
    // internal oscillator as divider
    if (st_r.osc_cnt == 8'(OSC_HALF - 1)) begin
      st_nxt.osc_cnt = 8'h00;
      st_nxt.osc = !st_r.osc;
    end else begin
      st_nxt.osc_cnt = st_r.osc_cnt + 8'h01;
    end
    // row scan on display clock rising edges
    if (clk_src && !st_r.eclk_q) begin
      st_nxt.tick = 1'b1;
      if (st_r.row_cnt == 8'(ROW_LEN - 1)) begin
        st_nxt.row_cnt = 8'h00;
        st_nxt.row = (st_r.row == 6'(ROWS - 1)) ? 6'h00 : st_r.row + 6'h01;
      end else begin
        st_nxt.row_cnt = st_r.row_cnt + 8'h01;
      end
    end
    // slave realigns scan on master frame sync
    if (cascade_en && !cascade_master && s_fs) begin
      st_nxt.row = 6'(ROWS - 1);
    end
    st_nxt.fm = (st_nxt.row == 6'(ROWS - 1));
    st_nxt.ds = s_don;
    // select gating, idle resets serial state
    if (!sel) begin
      st_nxt.shift = ddhp_pkg::BYTE_RST;
      st_nxt.bitcnt = ddhp_pkg::BITCNT_RST;
      st_nxt.nib_hi = 1'b1;
    end else if (is8080) begin
      // capture on write strobe rise, fields sampled together
      if (s_wr && !st_r.wr_q) begin
        st_nxt.xf.data = is4bit ? {s_d[7:4], 4'h0} : s_d;
        st_nxt.xf.is_data = s_dc;
        st_nxt.xf.is_read = 1'b0;
        st_nxt.xf.nibble_hi = st_r.nib_hi;
        st_nxt.vld = 1'b1;
        st_nxt.nib_hi = is4bit ? !st_r.nib_hi : 1'b1;
      end
      if (!s_rd && st_r.rd_q) begin
        st_nxt.dout = rd_data;
      end
    end else if (is6800) begin
      if (st_r.rd_q && !s_rd) begin
        st_nxt.xf.data = is4bit ? {s_d[7:4], 4'h0} : s_d;
        st_nxt.xf.is_data = s_dc;
        st_nxt.xf.is_read = s_wr;
        st_nxt.xf.nibble_hi = st_r.nib_hi;
        st_nxt.vld = 1'b1;
        st_nxt.nib_hi = is4bit ? !st_r.nib_hi : 1'b1;
      end
      if (s_rd && !st_r.rd_q) begin
        st_nxt.dout = rd_data;
      end
    end else if (isspi4 && sclk_rise) begin
      st_nxt.shift = {st_r.shift[6:0], s_d[ddhp_pkg::PIN_SDI]};
      if (st_r.bitcnt == 4'(ddhp_pkg::SER_BITS - 1)) begin
        st_nxt.bitcnt = ddhp_pkg::BITCNT_RST;
        st_nxt.xf.data = {st_r.shift[6:0], s_d[ddhp_pkg::PIN_SDI]};
        st_nxt.xf.is_data = s_dc;
        st_nxt.xf.is_read = 1'b0;
        st_nxt.xf.nibble_hi = 1'b1;
        st_nxt.vld = 1'b1;
      end else begin
        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
      end
    end
    if (in_init) begin
      st_nxt.vld = 1'b0;
      st_nxt.nib_hi = 1'b1;
      st_nxt.bitcnt = ddhp_pkg::BITCNT_RST;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // data pad drive
  // ----------------------------------------
  logic rd_active;
  // 8080 read low; 6800 direction high with enable
  assign rd_active = sel && ((is8080 && !s_rd) || (is6800 && s_wr && s_rd));

  genvar gi;
  generate
    for (gi = 0; gi < ddhp_pkg::DATA_W; gi++) begin : g_pad
      // 4-bit releases low nibble, serial releases all, deselect
      if (gi < ddhp_pkg::NIB_W) begin : g_lo
        assign d_oe[gi] = rd_active && !is4bit;
        assign d_o[gi] = st_r.dout[gi];
      end else begin : g_hi
        assign d_oe[gi] = rd_active;
        assign d_o[gi] = is4bit ? st_r.dout[gi - ddhp_pkg::NIB_W + (st_r.nib_hi ? 4 : 0)]
                                : st_r.dout[gi];
      end
    end
  endgenerate

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign xfer = st_r.xf;
  assign xfer_vld = st_r.vld;
  assign slave_addr_lsb = istwi ? s_dc : 1'b0;
  assign settings_init = in_init;
  assign display_clk_pad_o = st_r.osc;
  assign display_clk_pad_oe = osc_enable_pad;
  assign disp_clk_tick = st_r.tick;
  assign cascade_shift_clk_o = clk_src;
  assign cascade_shift_clk_oe = cascade_en && cascade_master;
  assign cascade_pattern_data_o = pattern_bit;
  assign cascade_pattern_data_oe = cascade_en && cascade_master;
  assign pattern_rx = (cascade_en && !cascade_master) ? s_pat : 1'b0;
  assign cascade_frame_sync_o = st_r.fm;
  assign cascade_frame_sync_oe = cascade_en && cascade_master;
  assign unused_latch_out = 1'b0;
  assign frame_marker = st_r.fm;
  assign display_state = st_r.ds;

  logic unused_ok;
  assign unused_ok = s_sclk_c;

endmodule : ddhp_top
`default_nettype wire

// >>> test/ddhp_host.sv
// Purpose: host processor model for the pad logic
// Assumes: strobes held 4 clocks, past the 3-clock minimum
// Notes: a released data line shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none

module ddhp_host (
  // clock
  input wire logic clock,
  // host pads
  output logic cs_n,
  output logic data_cmd_sel,
  output logic wr_dir,
  output logic rd_en,
  output logic [7:0] d_i,
  // device drive
  input wire logic [7:0] d_o,
  input wire logic [7:0] d_oe
);
  logic [7:0] hd = 8'h00;
  logic hoe = 1'b0;

  initial begin
    cs_n = 1'b1;
    data_cmd_sel = 1'b0;
    wr_dir = 1'b1;
    rd_en = 1'b1;
  end

  assign d_i = (d_o & d_oe) | ((hoe ? hd : ~hd) & ~d_oe);

  task automatic op(input logic m68, input logic rd, input logic dc, input logic sel,
                    input logic [7:0] v, output logic [7:0] q);
    @(posedge clock);
    wr_dir <= m68 ? rd : 1'b1;
    rd_en <= ~m68;
    repeat (4) @(posedge clock);
    cs_n <= ~sel;
    data_cmd_sel <= dc;
    hd <= v;
    hoe <= ~rd;
    repeat (4) @(posedge clock);
    if (m68) rd_en <= 1'b1;
    else if (rd) rd_en <= 1'b0;
    else wr_dir <= 1'b0;
    repeat (4) @(posedge clock);
    q = d_i;
    rd_en <= ~m68;
    wr_dir <= m68 ? rd : 1'b1;
    repeat (6) @(posedge clock);
  endtask : op

  task automatic spi(input logic dc, input logic [7:0] v);
    @(posedge clock);
    hd <= 8'h00;
    hoe <= 1'b1;
    cs_n <= 1'b0;
    data_cmd_sel <= dc;
    // data on pin 1 while clock low, msb first
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge clock);
      hd <= {6'h00, v[i], 1'b0};
      repeat (4) @(posedge clock);
      hd[0] <= 1'b1;
    end
    repeat (4) @(posedge clock);
    hd[0] <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : spi

  task automatic release_bus;
    @(posedge clock);
    cs_n <= 1'b1;
    hoe <= 1'b0;
  endtask : release_bus
endmodule : ddhp_host

`default_nettype wire

// >>> test/ddhp_top_assertions.sv
// Purpose: port checks for ddhp_top
// Assumes: straps change only while the host is idle
// Notes: windows cover two sync flops and one register
`timescale 1ns/100ps
`default_nettype none

module ddhp_top_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // host pads
  input wire logic hw_init_n,
  input wire logic cs_n,
  input wire logic rd_en,
  input wire logic [2:0] if_mode,
  input wire logic [7:0] d_oe,
  // straps and indicators
  input wire logic osc_enable_pad,
  input wire logic cascade_en,
  input wire logic cascade_master,
  input wire logic display_on,
  input wire logic display_clk_pad_oe,
  input wire logic cascade_frame_sync_o,
  input wire logic cascade_frame_sync_oe,
  input wire logic frame_marker,
  input wire logic display_state,
  input wire logic settings_init,
  input wire logic xfer_vld
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ----
  // sequences
  // ----
  // rst kept in the window so sync flops have refilled
  sequence s_desel;
    (!rst && cs_n) [*6];
  endsequence
  sequence s_calm(sig);
    (!rst && $stable(sig)) [*4];
  endsequence

  // ----
  // properties
  // ----
  property p_desel_hiz;
    s_desel |-> d_oe == 8'h00;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz)
    else $error("pins driven while idle");
  property p_desel_drop;
    s_desel |-> !xfer_vld;
  endproperty
  a_desel_drop: assert property (p_desel_drop)
    else $error("transfer while idle");
  property p_init_lvl;
    s_calm(hw_init_n) |-> settings_init == !hw_init_n;
  endproperty
  a_init_lvl: assert property (p_init_lvl)
    else $error("init level wrong");
  property p_init_drop;
    (!rst && !hw_init_n) [*6] |-> !xfer_vld;
  endproperty
  a_init_drop: assert property (p_init_drop)
    else $error("transfer during init");
  property p_rd_drive;
    (!rst && !cs_n && $stable(rd_en) && if_mode == ddhp_pkg::MODE_P8_8080) [*4]
      |-> d_oe == {8{!rd_en}};
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read drive wrong");
  property p_nib_low;
    (if_mode == ddhp_pkg::MODE_P4_6800 || if_mode == ddhp_pkg::MODE_P4_8080)
      |-> d_oe[3:0] == 4'h0;
  endproperty
  a_nib_low: assert property (p_nib_low)
    else $error("low nibble driven");
  property p_ser_hiz;
    if_mode[1] |-> d_oe == 8'h00;
  endproperty
  a_ser_hiz: assert property (p_ser_hiz)
    else $error("serial pins driven");
  property p_osc_pad;
    display_clk_pad_oe == osc_enable_pad;
  endproperty
  a_osc_pad: assert property (p_osc_pad)
    else $error("clock pad dir wrong");
  property p_casc;
    cascade_frame_sync_oe == (cascade_en && cascade_master)
      && (!cascade_frame_sync_oe || cascade_frame_sync_o == frame_marker);
  endproperty
  a_casc: assert property (p_casc)
    else $error("frame sync wrong");
  property p_disp_state;
    s_calm(display_on) |-> display_state == display_on;
  endproperty
  a_disp_state: assert property (p_disp_state)
    else $error("display state wrong");
endmodule : ddhp_top_chk

bind ddhp_top ddhp_top_chk i_ddhp_top_chk (
  .clock, .rst, .hw_init_n, .cs_n, .rd_en, .if_mode, .d_oe, .osc_enable_pad, .cascade_en,
  .cascade_master, .display_on, .display_clk_pad_oe, .cascade_frame_sync_o,
  .cascade_frame_sync_oe, .frame_marker, .display_state, .settings_init, .xfer_vld);

`default_nettype wire

// >>> test/ddhp_top_tb.sv
// Purpose: self-checking bench for ddhp_top
// Assumes: short counts through OSC_HALF, ROWS and ROW_LEN
// Notes: rows are {6800, read, data_cmd_sel, data}
`timescale 1ns/100ps
`default_nettype none

module ddhp_top_tb;
  localparam int OSC_HALF = 2;
  localparam int ROWS = 4;
  localparam int ROW_LEN = 2;
  localparam int FRAME = ROWS * ROW_LEN * 2 * OSC_HALF;
  logic clock, rst, hw_init_n, cs_n, data_cmd_sel, wr_dir, rd_en, osc_enable_pad;
  logic cascade_en, cascade_master, display_on, xfer_vld, settings_init;
  logic frame_marker, display_state, m68, rd, dc;
  logic pat, sa_lsb, pat_o, pat_rx, sh_oe, tick;
  int nt = 0;
  logic [2:0] if_mode;
  logic [7:0] d_i, d_o, d_oe, rd_data, v, q;
  ddhp_pkg::ddhp_xfer_t xfer, got;
  int errors = 0;
  int n_compared = 0;
  int n_vld = 0;
  int n0, hi;
  logic [10:0] rows [6] = '{11'h15a, 11'h0ff, 11'h33c, 11'h5a5, 11'h400, 11'h6c3};

  ddhp_top #(.OSC_HALF(OSC_HALF), .ROWS(ROWS), .ROW_LEN(ROW_LEN)) i_ddhp_top (
    .clock, .rst, .hw_init_n, .cs_n, .data_cmd_sel, .wr_dir, .rd_en, .d_i, .d_o, .d_oe,
    .if_mode, .osc_enable_pad, .cascade_en, .cascade_master, .xfer, .xfer_vld,
    .slave_addr_lsb(sa_lsb), .settings_init, .rd_data, .display_on, .pattern_bit(pat),
    .display_clk_pad_i(1'b0), .display_clk_pad_o(), .display_clk_pad_oe(), .disp_clk_tick(tick),
    .cascade_shift_clk_i(1'b0), .cascade_shift_clk_o(), .cascade_shift_clk_oe(sh_oe),
    .cascade_pattern_data_i(pat), .cascade_pattern_data_o(pat_o), .cascade_pattern_data_oe(),
    .cascade_frame_sync_i(1'b0), .cascade_frame_sync_o(), .cascade_frame_sync_oe(),
    .pattern_rx(pat_rx), .unused_latch_out(), .frame_marker, .display_state);
  ddhp_host i_ddhp_host (.clock, .cs_n, .data_cmd_sel, .wr_dir, .rd_en, .d_i, .d_o, .d_oe);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    if (xfer_vld === 1'b1) begin
      got <= xfer;
      n_vld <= n_vld + 1;
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    hw_init_n = 1'b1;
    if_mode = ddhp_pkg::MODE_P8_8080;
    osc_enable_pad = 1'b1;
    cascade_en = 1'b1;
    cascade_master = 1'b1;
    display_on = 1'b0;
    rd_data = 8'h00;
    pat = 1'b1;
    repeat (8) @(posedge clock);
    chk({13'h0, xfer_vld, frame_marker, display_state}, 16'h0);
    rst <= 1'b0;
    display_on <= 1'b1;
    repeat (4) @(posedge clock);
    // ----
    // table of parallel transfers
    // ----
    foreach (rows[k]) begin
      {m68, rd, dc, v} = rows[k];
      if_mode <= m68 ? ddhp_pkg::MODE_P8_6800 : ddhp_pkg::MODE_P8_8080;
      rd_data <= ~v;
      n0 = n_vld;
      i_ddhp_host.op(m68, rd, dc, 1'b1, v, q);
      i_ddhp_host.release_bus();
      if (rd) chk({8'h0, q}, {8'h0, ~v});
      else chk({4'h0, got[10:1], 2'(n_vld - n0)}, {4'h0, v, dc, 1'b0, 2'h1});
    end
    // ----
    // refusals, nibbles, serial, indicators
    // ----
    if_mode <= ddhp_pkg::MODE_P8_8080;
    n0 = n_vld;
    i_ddhp_host.op(1'b0, 1'b0, 1'b1, 1'b0, 8'h77, q);
    hw_init_n <= 1'b0;
    i_ddhp_host.op(1'b0, 1'b0, 1'b1, 1'b1, 8'h11, q);
    i_ddhp_host.release_bus();
    chk({15'h0, settings_init}, 16'h1);
    hw_init_n <= 1'b1;
    chk(16'(n_vld - n0), 16'h0);
    if_mode <= ddhp_pkg::MODE_P4_8080;
    i_ddhp_host.op(1'b0, 1'b0, 1'b1, 1'b1, 8'hb0, q);
    chk({11'h0, got[10:7], got[0]}, {11'h0, 4'hb, 1'b1});
    i_ddhp_host.op(1'b0, 1'b0, 1'b1, 1'b1, 8'h4f, q);
    chk({11'h0, got[10:7], got[0]}, {11'h0, 4'h4, 1'b0});
    i_ddhp_host.release_bus();
    if_mode <= ddhp_pkg::MODE_SPI4;
    repeat (4) @(posedge clock);
    i_ddhp_host.spi(1'b1, 8'h96);
    i_ddhp_host.release_bus();
    chk({6'h0, got[10:1]}, {6'h0, 8'h96, 1'b1, 1'b0});
    chk({15'h0, sa_lsb}, 16'h0);
    if_mode <= ddhp_pkg::MODE_TWI_A;
    @(posedge clock);
    @(posedge clock);
    chk({15'h0, sa_lsb}, 16'h1);
    hi = 0;
    repeat (2 * FRAME) begin
      @(posedge clock);
      hi += frame_marker;
      nt += tick;
    end
    chk(16'(hi), 16'(4 * ROW_LEN * OSC_HALF));
    chk(16'(nt), 16'(2 * ROWS * ROW_LEN));
    chk({13'h0, pat_o, pat_rx, sh_oe}, 16'h5);
    chk({15'h0, display_state}, 16'h1);
    cascade_master <= 1'b0;
    display_on <= 1'b0;
    osc_enable_pad <= 1'b0;
    repeat (8) @(posedge clock);
    nt = 0;
    repeat (8) begin
      @(posedge clock);
      nt += tick;
    end
    chk({14'h0, pat_rx, sh_oe}, 16'h2);
    chk(16'(nt), 16'h0);
    cascade_en <= 1'b0;
    repeat (8) @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    chk({13'h0, xfer_vld, frame_marker, display_state}, 16'h0);
    test_done();
  end
endmodule : ddhp_top_tb

`default_nettype wire
